// *** cdd_assertions.sv ***
// Bus-level checker for the compact data-processing decoder.
// Assumes it is bound to cdd_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cdd_chk
  import cdd_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O
);
  // ==========================================================================
  // Helpers
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire logic rdq = req && !WB_WE_I;
  wire logic unm = (WB_ADR_I > ADR_W'(8'h08) && WB_ADR_I < ADR_W'(8'h40))
    || WB_ADR_I >= ADR_W'(8'h80);

  // ==========================================================================
  // Properties
  property p_ack_next;
    req |=> WB_ACK_O;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    WB_ACK_O |-> $past(req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_hold;
    !req && !SRST |=> $stable(WB_DAT_O);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data changed while idle");
  property p_unmapped;
    rdq && unm |=> WB_DAT_O == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_flags_pad;
    rdq && WB_ADR_I == ADR_W'(CDD_ADR_FLAGS) |=> WB_DAT_O[27:0] == 28'h0;
  endproperty
  a_flags_pad: assert property (p_flags_pad) else $error("flags read padding");
  property p_status_pad;
    rdq && WB_ADR_I == ADR_W'(CDD_ADR_STATUS) |=> WB_DAT_O[31:8] == 24'h0
      && WB_DAT_O[3] == 1'b0 && (!WB_DAT_O[0] || WB_DAT_O[7:1] == 7'h0);
  endproperty
  a_status_pad: assert property (p_status_pad) else $error("status read malformed");
  property p_instr_pad;
    rdq && WB_ADR_I == ADR_W'(CDD_ADR_INSTR) |=> WB_DAT_O[31:16] == 16'h0;
  endproperty
  a_instr_pad: assert property (p_instr_pad) else $error("instr read padding");
  c_write: cover property (req && WB_WE_I && WB_ADR_I == ADR_W'(CDD_ADR_INSTR));
  c_read: cover property (rdq && WB_ADR_I == ADR_W'(CDD_ADR_STATUS));
  c_unmapped: cover property (rdq && unm);
endmodule

bind cdd_top cdd_chk #(.ADR_W(ADR_W)) u_chk (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// *** cdd_pkg.sv ***
// Constants, types and register map of the compact data-processing decoder.
// Assumes one core clock; software drives everything over a Wishbone slave.
package cdd_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CDD_ADR_INSTR = 8'h00;
  localparam logic [7:0] CDD_ADR_FLAGS = 8'h04;
  localparam logic [7:0] CDD_ADR_STATUS = 8'h08;
  localparam logic [1:0] CDD_GPR_WIN = 2'h1;
  localparam int CDD_GPR_WIN_LSB = 6;
  localparam int CDD_GPR_IDX_LSB = 2;
  localparam int CDD_FLAGS_LSB = 28;

  // ==========================================================================
  // Status fields
  localparam int CDD_ST_UNDEF = 0;
  localparam int CDD_ST_WROTE = 1;
  localparam int CDD_ST_FLAGS = 2;
  localparam int CDD_ST_DST_LSB = 4;

  // ==========================================================================
  // Register numbers
  localparam logic [3:0] CDD_SP_IDX = 4'hd;
  localparam logic [3:0] CDD_PC_IDX = 4'hf;

  // ==========================================================================
  // Format patterns
  localparam logic [2:0] CDD_PAT_SHIMM = 3'h0;
  localparam logic [5:0] CDD_PAT_THREE = 6'h06;
  localparam logic [5:0] CDD_PAT_SMALL = 6'h07;
  localparam logic [2:0] CDD_PAT_IMM8 = 3'h1;
  localparam logic [5:0] CDD_PAT_TWO = 6'h10;
  localparam logic [5:0] CDD_PAT_UPPER = 6'h11;
  localparam logic [3:0] CDD_PAT_ADR = 4'ha;
  localparam logic [7:0] CDD_PAT_SP = 8'hb0;

  // ==========================================================================
  // Operation codes
  localparam logic [1:0] CDD_SK_LSL = 2'h0;
  localparam logic [1:0] CDD_SK_LSR = 2'h1;
  localparam logic [1:0] CDD_SK_ASR = 2'h2;
  localparam logic [1:0] CDD_SK_ROR = 2'h3;
  localparam logic [1:0] CDD_I8_MOV = 2'h0;
  localparam logic [1:0] CDD_I8_CMP = 2'h1;
  localparam logic [1:0] CDD_I8_ADD = 2'h2;
  localparam logic [1:0] CDD_I8_SUB = 2'h3;
  localparam logic [1:0] CDD_UP_ADD = 2'h0;
  localparam logic [1:0] CDD_UP_CMP = 2'h1;
  localparam logic [1:0] CDD_UP_MOV = 2'h2;
  localparam logic [3:0] CDD_OP_AND = 4'h0;
  localparam logic [3:0] CDD_OP_EOR = 4'h1;
  localparam logic [3:0] CDD_OP_LSL = 4'h2;
  localparam logic [3:0] CDD_OP_LSR = 4'h3;
  localparam logic [3:0] CDD_OP_ASR = 4'h4;
  localparam logic [3:0] CDD_OP_ADC = 4'h5;
  localparam logic [3:0] CDD_OP_SBC = 4'h6;
  localparam logic [3:0] CDD_OP_ROR = 4'h7;
  localparam logic [3:0] CDD_OP_TST = 4'h8;
  localparam logic [3:0] CDD_OP_NEG = 4'h9;
  localparam logic [3:0] CDD_OP_CMP = 4'ha;
  localparam logic [3:0] CDD_OP_CMN = 4'hb;
  localparam logic [3:0] CDD_OP_ORR = 4'hc;
  localparam logic [3:0] CDD_OP_MUL = 4'hd;
  localparam logic [3:0] CDD_OP_BIC = 4'he;
  localparam logic [3:0] CDD_OP_MVN = 4'hf;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    FORM_NONE, FORM_SHIMM, FORM_THREE, FORM_SMALL, FORM_IMM8,
    FORM_TWO, FORM_UPPER, FORM_ADR, FORM_SP
  } cdd_form_e;

  typedef struct packed {
    cdd_form_e form;
    logic wr;
    logic [3:0] dst;
    logic [31:0] val;
    logic fupd;
    logic [3:0] nzcv;
  } cdd_exe_s;

  typedef struct packed {
    logic [15:0][31:0] gpr;
    logic [3:0] nzcv;
    logic [15:0] instr;
    logic [7:0] status;
    logic ack;
    logic [31:0] dat;
  } cdd_state_s;

  localparam cdd_state_s CDD_STATE_RST = '0;

endpackage

// *** cdd_top.sv ***
// Decoder and executor for the compact data-processing group, with its own
// register file and flags, all reached over a classic Wishbone slave.
// Assumes a Wishbone master on SYS_CLK; no other party drives the block.
`timescale 1ns/10ps
`default_nettype none
module cdd_top
  import cdd_pkg::*;
#(
  parameter int ADR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  if (ADR_W < 8) begin : g_chk
    $error("ADR_W must be at least 8");
  end

  // ==========================================================================
  // Arithmetic helpers
  // Returns {carry, overflow, sum}
  function automatic logic [33:0] add_cv(input logic [31:0] a, input logic [31:0] b,
                                         input logic ci);
    logic [32:0] s;
    logic v;
    s = {1'b0, a} + {1'b0, b} + {32'h0, ci};
    v = (a[31] == b[31]) && (s[31] != a[31]);
    return {s[32], v, s[31:0]};
  endfunction

  // Flags after an adder result
  function automatic logic [3:0] add_flags(input logic [33:0] ad);
    return {ad[31], ad[31:0] == 32'h0, ad[33], ad[32]};
  endfunction

  // Flags after a logic or shift result; V kept
  function automatic logic [3:0] lg_flags(input logic [31:0] r, input logic c,
                                          input logic v);
    return {r[31], r == 32'h0, c, v};
  endfunction

  // Returns {carry, result}; amount zero keeps value and carry
  function automatic logic [32:0] shift_op(input logic [1:0] kind, input logic [31:0] val,
                                           input logic [7:0] amt, input logic ci);
    logic [5:0] ac;
    logic [63:0] tl;
    logic [32:0] tr;
    logic [63:0] rr;
    logic [32:0] res;
    ac = (amt > 8'h21) ? 6'h21 : amt[5:0];
    tl = {32'h0, val} << ac;
    rr = {val, val} >> amt[4:0];
    tr = 33'h0;
    res = {ci, val};
    unique case (kind)
      CDD_SK_LSL: res = {tl[32], tl[31:0]};
      CDD_SK_LSR: begin
        tr = {val, 1'b0} >> ac;
        res = {tr[0], tr[32:1]};
      end
      CDD_SK_ASR: begin
        tr = 33'($signed({val, 1'b0}) >>> ac);
        res = {tr[0], tr[32:1]};
      end
      CDD_SK_ROR: res = {rr[31], rr[31:0]};
    endcase
    if (amt == 8'h0) begin
      res = {ci, val};
    end
    return res;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        r[8*k +: 8] = nw[8*k +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Format decode
  function automatic cdd_form_e decode(input logic [15:0] i);
    cdd_form_e f;
    f = FORM_NONE;
    if (i[15:10] == CDD_PAT_THREE) begin
      f = FORM_THREE;
    end else if (i[15:10] == CDD_PAT_SMALL) begin
      f = FORM_SMALL;
    end else if (i[15:13] == CDD_PAT_SHIMM) begin
      f = FORM_SHIMM;
    end else if (i[15:13] == CDD_PAT_IMM8) begin
      f = FORM_IMM8;
    end else if (i[15:10] == CDD_PAT_TWO) begin
      f = FORM_TWO;
    end else if (i[15:10] == CDD_PAT_UPPER && i[9:8] != 2'h3) begin
      f = FORM_UPPER;
    end else if (i[15:12] == CDD_PAT_ADR) begin
      f = FORM_ADR;
    end else if (i[15:8] == CDD_PAT_SP) begin
      f = FORM_SP;
    end
    return f;
  endfunction

  // ==========================================================================
  // Execute one halfword against the register file and flags
  function automatic cdd_exe_s execute(input logic [15:0] i,
                                       input logic [15:0][31:0] g,
                                       input logic [3:0] fl);
    cdd_exe_s e;
    logic [33:0] ad;
    logic [32:0] sh;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] imm;
    logic [31:0] base;
    logic [7:0] amt;
    logic [3:0] hd;
    logic [3:0] hm;
    logic [1:0] sk;
    e.form = decode(i);
    e.wr = 1'b0;
    e.dst = {1'b0, i[2:0]};
    e.val = 32'h0;
    e.fupd = 1'b0;
    e.nzcv = fl;
    d = g[{1'b0, i[2:0]}];
    m = g[{1'b0, i[5:3]}];
    imm = {24'h0, i[7:0]};
    hd = {i[7], i[2:0]};
    hm = {i[6], i[5:3]};
    unique case (e.form)
      FORM_NONE: e.wr = 1'b0;
      FORM_SHIMM: begin
        amt = {3'h0, i[10:6]};
        if (i[10:6] == 5'h0 && i[12:11] != CDD_SK_LSL) begin
          amt = 8'h20;
        end
        sh = shift_op(i[12:11], m, amt, fl[1]);
        e.wr = 1'b1;
        e.val = sh[31:0];
        e.fupd = 1'b1;
        e.nzcv = lg_flags(sh[31:0], sh[32], fl[0]);
      end
      FORM_THREE, FORM_SMALL: begin
        base = (e.form == FORM_THREE) ? g[{1'b0, i[8:6]}] : {29'h0, i[8:6]};
        ad = i[9] ? add_cv(m, ~base, 1'b1) : add_cv(m, base, 1'b0);
        e.wr = 1'b1;
        e.val = ad[31:0];
        e.fupd = 1'b1;
        e.nzcv = add_flags(ad);
      end
      FORM_IMM8: begin
        e.dst = {1'b0, i[10:8]};
        d = g[{1'b0, i[10:8]}];
        ad = (i[12:11] == CDD_I8_ADD) ? add_cv(d, imm, 1'b0) : add_cv(d, ~imm, 1'b1);
        e.fupd = 1'b1;
        e.wr = (i[12:11] != CDD_I8_CMP);
        e.val = (i[12:11] == CDD_I8_MOV) ? imm : ad[31:0];
        e.nzcv = (i[12:11] == CDD_I8_MOV) ? lg_flags(imm, fl[1], fl[0]) : add_flags(ad);
      end
      FORM_TWO: begin
        e.wr = 1'b1;
        e.fupd = 1'b1;
        ad = add_cv(d, m, 1'b0);
        sh = shift_op(CDD_SK_LSL, d, m[7:0], fl[1]);
        e.val = 32'h0;
        unique case (i[9:6])
          CDD_OP_AND, CDD_OP_TST: e.val = d & m;
          CDD_OP_EOR: e.val = d ^ m;
          CDD_OP_ORR: e.val = d | m;
          CDD_OP_BIC: e.val = d & ~m;
          CDD_OP_MVN: e.val = ~m;
          CDD_OP_MUL: e.val = 32'(d * m);
          CDD_OP_LSL, CDD_OP_LSR, CDD_OP_ASR, CDD_OP_ROR: begin
            sk = (i[9:6] == CDD_OP_LSL) ? CDD_SK_LSL : ((i[9:6] == CDD_OP_LSR) ? CDD_SK_LSR
                 : ((i[9:6] == CDD_OP_ASR) ? CDD_SK_ASR : CDD_SK_ROR));
            sh = shift_op(sk, d, m[7:0], fl[1]);
            e.val = sh[31:0];
          end
          CDD_OP_ADC: ad = add_cv(d, m, fl[1]);
          CDD_OP_SBC: ad = add_cv(d, ~m, fl[1]);
          CDD_OP_NEG: ad = add_cv(32'h0, ~m, 1'b1);
          CDD_OP_CMP: ad = add_cv(d, ~m, 1'b1);
          CDD_OP_CMN: ad = add_cv(d, m, 1'b0);
        endcase
        unique case (i[9:6])
          CDD_OP_ADC, CDD_OP_SBC, CDD_OP_NEG, CDD_OP_CMP, CDD_OP_CMN: begin
            e.val = ad[31:0];
            e.nzcv = add_flags(ad);
          end
          CDD_OP_LSL, CDD_OP_LSR, CDD_OP_ASR, CDD_OP_ROR:
            e.nzcv = lg_flags(sh[31:0], sh[32], fl[0]);
          default: e.nzcv = lg_flags(e.val, fl[1], fl[0]);
        endcase
        if (i[9:6] == CDD_OP_TST || i[9:6] == CDD_OP_CMP || i[9:6] == CDD_OP_CMN) begin
          e.wr = 1'b0;
        end
      end
      FORM_UPPER: begin
        e.dst = hd;
        ad = (i[9:8] == CDD_UP_CMP) ? add_cv(g[hd], ~g[hm], 1'b1) : add_cv(g[hd], g[hm], 1'b0);
        e.wr = (i[9:8] != CDD_UP_CMP);
        e.val = (i[9:8] == CDD_UP_MOV) ? g[hm] : ad[31:0];
        e.fupd = (i[9:8] == CDD_UP_CMP);
        e.nzcv = add_flags(ad);
      end
      FORM_ADR: begin
        base = i[11] ? g[CDD_SP_IDX] : (g[CDD_PC_IDX] & ~32'h3);
        e.dst = {1'b0, i[10:8]};
        e.wr = 1'b1;
        e.val = base + {22'h0, i[7:0], 2'h0};
      end
      FORM_SP: begin
        base = {23'h0, i[6:0], 2'h0};
        e.dst = CDD_SP_IDX;
        e.wr = 1'b1;
        e.val = i[7] ? g[CDD_SP_IDX] - base : g[CDD_SP_IDX] + base;
      end
    endcase
    return e;
  endfunction

  // ==========================================================================
  // State and bus slave
  cdd_state_s s_r;
  cdd_state_s s_nxt;
  cdd_exe_s ex;
  logic req;
  logic [7:0] adr;
  logic hi_zero;
  logic in_win;
  logic wr_go;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    ex = execute(WB_DAT_I[15:0], s_r.gpr, s_r.nzcv);
    req = WB_CYC_I && WB_STB_I && !s_r.ack;
    adr = WB_ADR_I[7:0];
    hi_zero = (WB_ADR_I >> 8) == '0;
    in_win = hi_zero && adr[7:CDD_GPR_WIN_LSB] == CDD_GPR_WIN && adr[1:0] == 2'h0;
    wr_go = WB_CYC_I && WB_STB_I && WB_WE_I && s_r.ack;
    if (req) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = 32'h0;
      if (in_win) begin
        s_nxt.dat = s_r.gpr[adr[5:CDD_GPR_IDX_LSB]];
      end else if (hi_zero && adr == CDD_ADR_INSTR) begin
        s_nxt.dat = {16'h0, s_r.instr};
      end else if (hi_zero && adr == CDD_ADR_FLAGS) begin
        s_nxt.dat = {s_r.nzcv, 28'h0};
      end else if (hi_zero && adr == CDD_ADR_STATUS) begin
        s_nxt.dat = {24'h0, s_r.status};
      end
    end
    // Writes commit on the edge at which the master samples ack
    if (wr_go) begin
      if (in_win) begin
        s_nxt.gpr[adr[5:CDD_GPR_IDX_LSB]] =
          merge(s_r.gpr[adr[5:CDD_GPR_IDX_LSB]], WB_DAT_I, WB_SEL_I);
      end else if (hi_zero && adr == CDD_ADR_FLAGS && WB_SEL_I[3]) begin
        s_nxt.nzcv = WB_DAT_I[CDD_FLAGS_LSB +: 4];
      end else if (hi_zero && adr == CDD_ADR_INSTR && WB_SEL_I[1:0] == 2'h3) begin
        s_nxt.instr = WB_DAT_I[15:0];
        if (ex.wr) begin
          s_nxt.gpr[ex.dst] = ex.val;
        end
        if (ex.fupd) begin
          s_nxt.nzcv = ex.nzcv;
        end
        s_nxt.status = 8'h0;
        s_nxt.status[CDD_ST_UNDEF] = (ex.form == FORM_NONE);
        s_nxt.status[CDD_ST_WROTE] = ex.wr;
        s_nxt.status[CDD_ST_FLAGS] = ex.fupd;
        s_nxt.status[CDD_ST_DST_LSB +: 4] = ex.wr ? ex.dst : 4'h0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s_r <= CDD_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign WB_ACK_O = s_r.ack;
  assign WB_DAT_O = s_r.dat;

endmodule
`default_nettype wire

// *** cdd_wb_model.sv ***
// Classic Wishbone master standing in for software at the register bus.
// Assumes a slave that acks on its own; the caller bounds the wait.
`timescale 1ns/10ps
`default_nettype none
module cdd_wb_model (
  input wire logic clk,
  input wire logic [31:0] dat_i,
  input wire logic ack,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat_o
);
  initial begin
    {cyc, stb, we, adr, sel, dat_o} = '0;
  end
  // One single cycle; afterwards adr and dat_o show the inverse of the last value, we and sel keep it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_o <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_i;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// *** compact_dataproc_decode_tb_top.sv ***
// Self-checking bench: executes halfwords through the register bus.
// Assumes cdd_top with default ADR_W and the master model.
`timescale 1ns/10ps
`default_nettype none
module compact_dataproc_decode_tb_top;
  import cdd_pkg::*;
  logic sys_clk, srst, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] pv [16] = '{32'h0, 32'h1, 32'h2, 32'h80000000, 32'hffffffff, 32'h7fffffff,
    32'hf0f0, 32'h21, 32'h8, 32'h9, 32'ha, 32'hb, 32'hc, 32'h100, 32'he0, 32'h1002};
  // Halfword, flags in, dest, value, flags out, status
  logic [67:0] tv [36] = '{
    68'h1860_0_0_00000000_6_06, 68'h1a8f_0_7_ffffffff_8_76,
    68'h1dea_0_2_80000006_9_26, 68'h1e49_0_1_00000000_6_16,
    68'h26ff_3_6_000000ff_3_66, 68'h2902_0_1_00000001_8_04,
    68'h3401_0_4_00000000_6_46, 68'h38ff_0_0_ffffff01_8_06,
    68'h0068_1_0_fffffffe_9_06, 68'h081a_0_2_00000000_6_26,
    68'h1019_0_1_ffffffff_a_16, 68'h4026_0_6_0000f0f0_0_66,
    68'h4064_0_4_00000000_4_46, 68'h40b9_0_1_00000000_4_16,
    68'h40d3_0_3_20000000_0_36, 68'h410b_0_3_c0000000_8_36,
    68'h414d_2_5_80000001_9_56, 68'h418a_0_2_00000000_6_26,
    68'h41fe_0_6_00007878_0_66, 68'h420e_0_6_0000f0f0_4_04,
    68'h4248_0_0_ffffffff_8_06, 68'h42ab_0_3_80000000_3_04,
    68'h42cc_0_4_ffffffff_6_04, 68'h430e_0_6_0000f0f1_0_66,
    68'h4357_3_7_00000042_3_76, 68'h43b6_0_6_00000000_4_66,
    68'h43e0_0_0_00000000_4_06, 68'h44e8_f_8_00000108_f_82,
    68'h45da_0_a_0000000a_8_04, 68'h4660_5_0_0000000c_5_02,
    68'h4611_f_1_00000002_f_12, 68'hadff_0_5_000004fc_0_52,
    68'ha401_0_4_00001004_0_42, 68'hb07f_0_d_000002fc_0_d2,
    68'hb081_6_d_000000fc_6_d2, 68'h4700_9_0_00000000_9_01};

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  cdd_top uut (.SYS_CLK(sys_clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack));
  cdd_wb_model u_m (.clk(sys_clk), .dat_i(rdat), .ack(ack), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat_o(wdat));

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    u_m.xfer(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    u_m.xfer(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, e, q);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    for (int r = 0; r < 16; r++) rd(8'h40 + 8'(4 * r), 32'h0, "gpr reset");
    rd(CDD_ADR_FLAGS, 32'h0, "flags reset");
    rd(CDD_ADR_STATUS, 32'h0, "status reset");
    $display("Reset test done");
    foreach (tv[i]) begin
      for (int r = 0; r < 16; r++) wr(8'h40 + 8'(4 * r), pv[r], 4'hf);
      wr(CDD_ADR_FLAGS, {tv[i][51:48], 28'h0}, 4'hf);
      wr(CDD_ADR_INSTR, {16'h0, tv[i][67:52]}, 4'hf);
      rd({2'h1, tv[i][47:44], 2'h0}, tv[i][43:12], "dest");
      rd(CDD_ADR_FLAGS, {tv[i][11:8], 28'h0}, "flags");
      rd(CDD_ADR_STATUS, {24'h0, tv[i][7:0]}, "status");
    end
    $display("Execution test done");
    wr(CDD_ADR_FLAGS, 32'h3000_0000, 4'hf);
    wr(CDD_ADR_INSTR, 32'h0000_2105, 4'hf);
    wr(CDD_ADR_INSTR, 32'h0000_2203, 4'hc);
    rd(CDD_ADR_INSTR, 32'h0000_2105, "instr");
    rd(8'h44, 32'h5, "r1");
    wr(CDD_ADR_FLAGS, 32'hf000_0000, 4'h7);
    rd(CDD_ADR_FLAGS, 32'h3000_0000, "flags");
    wr(8'h20, 32'hdead_beef, 4'hf);
    rd(8'h20, 32'h0, "unmapped");
    wr(8'h44, 32'haabb_ccdd, 4'h2);
    rd(8'h44, 32'h0000_cc05, "byte lane");
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    rd(8'h44, 32'h0, "r1 after reset");
    $display("Bus test done");
    summarize();
  end
endmodule
`default_nettype wire
